// *** shared/wwdg_pkg.sv ***
/*
  Shared definitions for the windowed guard timer and its reset-cause flags: register
  indices, field positions, reset values, mode encodings and the carrier structs.
  Assumes a 32-bit APB slave whose byte address is four times the register index.
*/
package wwdg_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [11:0] IDX_GUARD_CONTROL_0 = 12'hed2;
   localparam logic [11:0] IDX_GUARD_CONTROL_1 = 12'hed3;
   localparam logic [11:0] IDX_PRESCALE_LOW    = 12'hed4;
   localparam logic [11:0] IDX_PRESCALE_HIGH   = 12'hed5;
   localparam logic [11:0] IDX_GUARD_COUNT     = 12'hed6;
   localparam logic [11:0] IDX_RESET_CAUSE     = 12'hfd7;

   // Field positions of the reset-cause register.
   localparam int unsigned WV_BIT  = 5;
   localparam int unsigned TO_BIT  = 4;
   localparam int unsigned PIN_BIT = 3;
   localparam int unsigned RI_BIT  = 2;
   localparam int unsigned POR_BIT = 1;
   localparam int unsigned BOR_BIT = 0;

   // Field positions inside the two control registers.
   localparam int unsigned PS_LSB     = 1;
   localparam int unsigned CLKSEL_LSB = 4;

   // Reset values; the brown-out flag is unknown after power-up and is taken as one here.
   localparam logic [7:0] FLAGS_RST     = 8'h3d;
   localparam logic [4:0] PRESCALE_RST  = 5'h0b;
   localparam logic [2:0] CLKSEL_RST    = 3'h0;
   localparam logic [2:0] OPENING_RST   = 3'h7;

   // Configuration codes that hand a field over to software, and the last valid prescale code.
   localparam logic [4:0] PS_FROM_REG   = 5'h1f;
   localparam logic [4:0] PS_LAST_VALID = 5'h12;
   localparam logic [2:0] OPEN_FULL     = 3'h7;

   // Guard mode encodings.
   localparam logic [1:0] MODE_ALWAYS   = 2'h3;
   localparam logic [1:0] MODE_AWAKE    = 2'h2;
   localparam logic [1:0] MODE_SOFT     = 2'h1;
   localparam logic [1:0] MODE_OFF      = 2'h0;

   // Clock source encodings.
   localparam logic [2:0] CLK_LOW_OSC   = 3'h0;
   localparam logic [2:0] CLK_MID_OSC   = 3'h1;

   // Configuration word fields that steer the guard timer.
   typedef struct packed {
      logic [1:0] guardModeConfig;
      logic [2:0] configClockSelect;
      logic [4:0] configPrescale;
      logic [2:0] configOpeningSize;
   } wwdg_cfg_t;

   // Reset causes reported by the system reset controller, one-cycle pulses.
   typedef struct packed {
      logic pwrOn;
      logic brownOut;
      logic pinReset;
      logic resetInstr;
   } wwdg_rst_evt_t;

   // Byte address of a register index on the 16-bit APB address.
   function automatic logic [15:0] regAddr(input logic [11:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

endpackage

// *** logic/wwdg_top.sv ***
/*
  Windowed guard timer with reset-cause flags, reached over APB.
  Assumes oscillator ticks, configuration words and core events arrive synchronous
  to core_clk; the oscillator ticks are one-cycle enables from outside.
*/
// The APB slave port and the register offsets were decided locally.
module wwdg_top
   import wwdg_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [15:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire wwdg_pkg::wwdg_cfg_t     cfg,
   input  wire wwdg_pkg::wwdg_rst_evt_t rstEvt,
   input  wire logic                    lowOscTick,
   input  wire logic                    midOscTick,
   input  wire logic                    clearInstr,
   input  wire logic                    sleeping,
   input  wire logic                    sleepExitIrq,
   input  wire logic                    oscStartupRunning,
   input  wire logic                    oscFailDetect,
   output logic                         guardResetReq,
   output logic                         wakeReq,
   output logic                         timeoutStatusN,
   output logic                         powerdownStatusN
);
   import wwdg_pkg::*;

   // Bus phases: the slave answers one cycle into the access phase.
   typedef enum logic {BUS_IDLE, BUS_READY} wwdg_bus_t;

   wwdg_bus_t   busState_r;       // APB answer phase.
   logic [17:0] preCnt_r;         // Prescale counter below the window count.
   logic [4:0]  guardCount_r;     // Five-bit count that decides the window.
   logic        armed_r;          // Set by a read of control register 0.
   logic        sleepPrev_r;      // Last sleep level, to see entry and exit.
   logic [4:0]  regPrescale_r;    // Software prescale select.
   logic        softEnable_r;     // Software enable bit.
   logic [2:0]  regClkSel_r;      // Software clock select.
   logic [2:0]  regOpening_r;     // Software window select.
   logic [7:0]  flags_r;          // Reset-cause register.
   logic        resetReq_r;       // Guard reset request pulse.
   logic        wakeReq_r;        // Wake request pulse.
   logic        toN_r;            // Time-out status, active low.
   logic        pdN_r;            // Power-down status, active low.
   logic [31:0] prdata_r;         // Captured read data.
   logic        pready_r;         // Bus answer.
   logic        pslverr_r;        // Unmapped-address answer.

   logic [2:0]  clkSelEff;        // Clock source in force.
   logic        tick;             // Selected oscillator tick.
   logic        active;           // Guard timer running.
   logic [4:0]  psEff;            // Prescale select in force.
   logic [17:0] psLast;           // Terminal prescale count.
   logic [2:0]  openEff;          // Window select in force.
   logic        windowed;         // Window narrower than the whole period.
   logic [4:0]  threshold;        // First count at which the window is open.
   logic        windowOpen;       // Window currently open.
   logic        busDone;          // Transfer completes at this edge.
   logic        busWr;            // Completing write.
   logic        busRd;            // Completing read.
   logic        mapped;           // Address hits a register.
   logic        ctrlWrite;        // Write to either control register.
   logic        clearTake;        // Clear instruction seen while running.
   logic        violation;        // Clear instruction refused.
   logic        validClear;       // Clear instruction accepted.
   logic        overflow;         // Counter reached the end of the period.
   logic        anyReset;         // Any system reset cause this cycle.
   logic        holdClear;        // Count is forced to zero.
   logic [31:0] readValue;        // Register contents at the current address.

   // Terminal prescale count; codes above the last valid one give the shortest period.
   function automatic logic [17:0] prescaleLast(input logic [4:0] ps);
      logic [17:0] one;
      one = 18'h00001;
      if (ps > PS_LAST_VALID) begin
         return 18'h00000;
      end
      return (one << ps) - one;
   endfunction

   // Address compare used by both read and write decode.
   function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
      return a == regAddr(idx);
   endfunction

   // Clock source, enable and period selection.
   always_comb begin
      clkSelEff  = cfg.guardModeConfig[1] ? cfg.configClockSelect : regClkSel_r;
      // Reserved source codes give no tick, so the timer stands still.
      tick       = (clkSelEff == CLK_LOW_OSC) ? lowOscTick :
                   (clkSelEff == CLK_MID_OSC) ? midOscTick : 1'b0;
      case (cfg.guardModeConfig)
         MODE_ALWAYS: active = 1'b1;
         MODE_AWAKE:  active = !sleeping;
         MODE_SOFT:   active = softEnable_r;
         MODE_OFF:    active = 1'b0;
         default:     active = 1'b0;
      endcase
      psEff      = (cfg.configPrescale == PS_FROM_REG) ? regPrescale_r
                                                       : cfg.configPrescale;
      psLast     = prescaleLast(psEff);
      openEff    = (cfg.configOpeningSize == OPEN_FULL) ? regOpening_r
                                                        : cfg.configOpeningSize;
      windowed   = openEff != OPEN_FULL;
      // Each code below full takes one eighth more of the period as closed time.
      threshold  = {~openEff, 2'b00};
      windowOpen = guardCount_r >= threshold;
   end

   // Bus decode; the transfer completes in the cycle when pready is high.
   always_comb begin
      busDone   = psel && penable && (busState_r == BUS_READY);
      busWr     = busDone && pwrite;
      busRd     = busDone && !pwrite;
      mapped    = hit(paddr, IDX_GUARD_CONTROL_0) || hit(paddr, IDX_GUARD_CONTROL_1) ||
                  hit(paddr, IDX_PRESCALE_LOW) || hit(paddr, IDX_PRESCALE_HIGH) ||
                  hit(paddr, IDX_GUARD_COUNT) || hit(paddr, IDX_RESET_CAUSE);
      ctrlWrite = busWr && (hit(paddr, IDX_GUARD_CONTROL_0) ||
                            hit(paddr, IDX_GUARD_CONTROL_1));
   end

   // Clear, violation, overflow and the conditions that hold the count at zero.
   always_comb begin
      clearTake  = active && clearInstr;
      violation  = clearTake && windowed && (!armed_r || !windowOpen);
      validClear = clearTake && !violation;
      overflow   = active && tick && (preCnt_r == psLast) && (guardCount_r == 5'h1f);
      anyReset   = rstEvt.pwrOn || rstEvt.brownOut || rstEvt.pinReset ||
                   rstEvt.resetInstr || resetReq_r;
      // The divider select of the core oscillator is not an input at all.
      holdClear  = anyReset || validClear || violation || !active ||
                   (sleeping != sleepPrev_r) || sleepExitIrq ||
                   oscStartupRunning || oscFailDetect ||
                   ctrlWrite;
   end

   // Read multiplexer; unused and reserved bits read as zero.
   always_comb begin
      readValue = 32'h00000000;
      if (hit(paddr, IDX_GUARD_CONTROL_0)) begin
         readValue[PS_LSB +: 5] = psEff;
         readValue[0]           = softEnable_r;
      end else if (hit(paddr, IDX_GUARD_CONTROL_1)) begin
         readValue[CLKSEL_LSB +: 3] = clkSelEff;
         readValue[2:0]             = openEff;
      end else if (hit(paddr, IDX_PRESCALE_LOW)) begin
         readValue[7:0] = preCnt_r[9:2];
      end else if (hit(paddr, IDX_PRESCALE_HIGH)) begin
         readValue[7:0] = preCnt_r[17:10];
      end else if (hit(paddr, IDX_GUARD_COUNT)) begin
         readValue[7:0] = {guardCount_r, active, preCnt_r[1:0]};
      end else if (hit(paddr, IDX_RESET_CAUSE)) begin
         readValue[7:0] = flags_r;
      end
   end

   // APB answer: one wait cycle, so that read data comes straight from a flip-flop.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busState_r <= BUS_IDLE;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         prdata_r   <= 32'h00000000;
      end else if (busState_r == BUS_IDLE && psel && penable) begin
         busState_r <= BUS_READY;
         pready_r   <= 1'b1;
         pslverr_r  <= !mapped;
         prdata_r   <= pwrite ? 32'h00000000 : readValue;
      end else begin
         busState_r <= BUS_IDLE;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
      end
   end

   // Software fields; the enable bit takes any write, the clock select only while configClockSelect is 7, the rest only while handed over.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regPrescale_r <= PRESCALE_RST;
         softEnable_r  <= 1'b0;
         regClkSel_r   <= CLKSEL_RST;
         regOpening_r  <= OPENING_RST;
      end else if (busWr && hit(paddr, IDX_GUARD_CONTROL_0)) begin
         softEnable_r <= pwdata[0];
         if (cfg.configPrescale == PS_FROM_REG) begin
            regPrescale_r <= pwdata[PS_LSB +: 5];
         end
      end else if (busWr && hit(paddr, IDX_GUARD_CONTROL_1)) begin
         if (cfg.configClockSelect == 3'h7) begin
            regClkSel_r <= pwdata[CLKSEL_LSB +: 3];
         end
         if (cfg.configOpeningSize == OPEN_FULL) begin
            regOpening_r <= pwdata[2:0];
         end
      end
   end

   // Arming: a read of control register 0 arms, an accepted or refused clear disarms.
   // A clear in the same cycle as the arming read wins, so the read must come first.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         armed_r <= 1'b0;
      end else if (clearTake || anyReset) begin
         armed_r <= 1'b0;
      end else if (busRd && hit(paddr, IDX_GUARD_CONTROL_0)) begin
         armed_r <= 1'b1;
      end
   end

   // Guard counter: prescaler below, five-bit window count above.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         preCnt_r     <= 18'h00000;
         guardCount_r <= 5'h00;
         sleepPrev_r  <= 1'b0;
      end else begin
         sleepPrev_r <= sleeping;
         if (holdClear || overflow) begin
            preCnt_r     <= 18'h00000;
            guardCount_r <= 5'h00;
         end else if (tick) begin
            if (preCnt_r == psLast) begin
               preCnt_r     <= 18'h00000;
               guardCount_r <= guardCount_r + 5'h01;
            end else begin
               preCnt_r <= preCnt_r + 18'h00001;
            end
         end
      end
   end

   // Reset and wake requests; a time-out asleep wakes the core instead of resetting it.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         resetReq_r <= 1'b0;
         wakeReq_r  <= 1'b0;
      end else begin
         resetReq_r <= violation || (overflow && !sleeping);
         wakeReq_r  <= overflow && sleeping;
      end
   end

   // Core status bits: both drop on a wake by time-out, sleep entry drops power-down.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         toN_r <= 1'b1;
         pdN_r <= 1'b1;
      end else if (overflow && sleeping) begin
         toN_r <= 1'b0;
         pdN_r <= 1'b0;
      end else if (validClear || rstEvt.pwrOn) begin
         toN_r <= 1'b1;
         pdN_r <= 1'b1;
      end else if (sleeping && !sleepPrev_r) begin
         pdN_r <= 1'b0;
      end
   end

   // Reset-cause flags. Software may write any value to bits 5:0 (7:6 stay zero) and no write starts a reset;
   // a hardware cause in the same cycle wins over the write so no event is lost.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flags_r <= FLAGS_RST;
      end else begin
         logic [7:0] f;
         f = flags_r;
         if (busWr && hit(paddr, IDX_RESET_CAUSE)) begin
            f = {2'b00, pwdata[5:0]};
         end
         if (rstEvt.pwrOn || rstEvt.brownOut) begin
            f[WV_BIT]  = 1'b1;
            f[TO_BIT]  = 1'b1;
            f[PIN_BIT] = 1'b1;
            f[RI_BIT]  = 1'b1;
         end
         if (rstEvt.pwrOn) begin
            f[POR_BIT] = 1'b0;
         end
         if (rstEvt.brownOut) begin
            f[BOR_BIT] = 1'b0;
         end
         if (rstEvt.pinReset) begin
            f[PIN_BIT] = 1'b0;
         end
         if (rstEvt.resetInstr) begin
            f[RI_BIT] = 1'b0;
         end
         if (violation) begin
            f[WV_BIT] = 1'b0;
         end
         if (overflow) begin
            f[TO_BIT] = 1'b0;
         end
         flags_r <= f;
      end
   end

   // Outputs come straight from flip-flops.
   assign prdata           = prdata_r;
   assign pready           = pready_r;
   assign pslverr          = pslverr_r;
   assign guardResetReq    = resetReq_r;
   assign wakeReq          = wakeReq_r;
   assign timeoutStatusN   = toN_r;
   assign powerdownStatusN = pdN_r;

   // Checks on the guard behaviour, all in the core_clk domain.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_unarmedClear;
      active && clearInstr && windowed && !armed_r;
   endsequence

   sequence s_violationSeen;
      guardResetReq && !flags_r[WV_BIT] ##1 guardCount_r == 5'h00;
   endsequence

   property p_unarmed;
      s_unarmedClear |=> s_violationSeen;
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("unarmed clear did not reset");

   property p_closed;
      active && clearInstr && windowed && armed_r && guardCount_r < threshold
         |=> guardResetReq && !flags_r[WV_BIT];
   endproperty
   a_closed: assert property (p_closed) else $error("closed window clear missed");

   property p_timeout;
      overflow && !sleeping |=> guardResetReq && !wakeReq && !flags_r[TO_BIT];
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out reset missing");

   property p_wake;
      overflow && sleeping |=> wakeReq && !guardResetReq && !timeoutStatusN &&
                              !powerdownStatusN;
   endproperty
   a_wake: assert property (p_wake) else $error("sleep time-out did not wake");

   property p_disabled;
      cfg.guardModeConfig == MODE_OFF [*2] |-> guardCount_r == 5'h00 && preCnt_r == 18'h0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("count moved while off");

   property p_ctrlWrite;
      ctrlWrite |=> guardCount_r == 5'h00 && preCnt_r == 18'h0;
   endproperty
   a_ctrlWrite: assert property (p_ctrlWrite) else $error("control write kept count");

   property p_disarm;
      validClear |=> !armed_r && guardCount_r == 5'h00;
   endproperty
   a_disarm: assert property (p_disarm) else $error("clear left timer armed");

   property p_powerOn;
      rstEvt.pwrOn |=> flags_r[5:2] == 4'hf && !flags_r[POR_BIT];
   endproperty
   a_powerOn: assert property (p_powerOn) else $error("power-on flags wrong");

   property p_pinKeepsPor;
      rstEvt.pinReset && !rstEvt.pwrOn && !busWr |=>
         !flags_r[PIN_BIT] && flags_r[POR_BIT] == $past(flags_r[POR_BIT]);
   endproperty
   a_pinKeepsPor: assert property (p_pinKeepsPor) else $error("pin reset flags wrong");

   property p_brownOut;
      rstEvt.brownOut && !rstEvt.pwrOn |=> !flags_r[BOR_BIT] && flags_r[RI_BIT];
   endproperty
   a_brownOut: assert property (p_brownOut) else $error("brown-out flags wrong");

endmodule

// *** testbench/wwdg_core_model.sv ***
/*
  Core-side model: turns bench commands into clear-instruction pulses.
  Knows nothing of arming; the bench also asks for windowed clears while unarmed, to see them refused.
*/
module wwdg_core_model
   import wwdg_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic clrCmd,
   output logic      clearInstr
);
   // A command retires as one clear instruction a cycle later.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clearInstr <= 1'b0;
      end else begin
         clearInstr <= clrCmd;
      end
   end
endmodule

// *** testbench/wwdg_top_tb.sv ***
/*
  Self-checking bench for the windowed guard timer and its reset-cause flags.
  Assumes the APB slave answers with one wait state and ticks may come every cycle.
*/
module wwdg_top_tb;
   import wwdg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic          core_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [15:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   wwdg_cfg_t     cfg;
   wwdg_rst_evt_t rstEvt;
   logic          tickEn, clrCmd, clearInstr, sleeping;
   logic          guardResetReq, wakeReq, timeoutStatusN, powerdownStatusN;
   int            errors, num_checks, cyc, rstN, wakeN, n, r0, w0;
   logic [5:0]    v;
   logic          err;            // pslverr as sampled at the completing edge.

   wwdg_top u_wwdg_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cfg(cfg), .rstEvt(rstEvt), .lowOscTick(tickEn),
      .midOscTick(1'b0), .clearInstr(clearInstr), .sleeping(sleeping),
      .sleepExitIrq(1'b0), .oscStartupRunning(1'b0), .oscFailDetect(1'b0),
      .guardResetReq(guardResetReq), .wakeReq(wakeReq),
      .timeoutStatusN(timeoutStatusN), .powerdownStatusN(powerdownStatusN));

   wwdg_core_model u_wwdg_core_model (.core_clk(core_clk), .rst(rst), .clrCmd(clrCmd),
      .clearInstr(clearInstr));

   // Free-running 50 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Counts request pulses and cuts a hang short.
   always @(posedge core_clk) begin
      cyc++;
      if (guardResetReq === 1'b1) rstN++;
      if (wakeReq === 1'b1) wakeN++;
      if (cyc > 20000) begin
         errors++;
         close_out();
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= regAddr(idx);
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // Issues a clear and checks whether a guard reset followed.
   task automatic clr(input logic viol);
      r0 = rstN;
      clrCmd <= 1'b1;
      @(posedge core_clk);
      clrCmd <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({31'h0, rstN > r0}, {31'h0, viol});
   endtask

   // Pulses one reset cause and reads the flags back.
   task automatic evt(input wwdg_rst_evt_t e, input logic [7:0] exp);
      rstEvt <= e;
      @(posedge core_clk);
      rstEvt <= '0;
      apb(1'b0, IDX_RESET_CAUSE, 32'h0);
      chk(rd, {24'h0, exp});
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      {rst, psel, penable, pwrite, tickEn, clrCmd, sleeping} = 7'h40;
      {paddr, pwdata, rstEvt, errors, num_checks, cyc, rstN, wakeN} = '0;
      cfg = '{MODE_OFF, CLK_LOW_OSC, PS_FROM_REG, OPEN_FULL};
      void'($urandom(32'h300c));
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, IDX_RESET_CAUSE, 32'h0);
      chk(rd, {24'h0, FLAGS_RST});
      apb(1'b0, IDX_GUARD_CONTROL_0, 32'h0);
      chk(rd, {26'h0, PRESCALE_RST, 1'b0});
      apb(1'b0, 12'h000, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Random flag pattern written by software must read back and never reset.
      v = 6'($urandom);
      apb(1'b1, IDX_RESET_CAUSE, {26'h0, v});
      apb(1'b0, IDX_RESET_CAUSE, 32'h0);
      chk(rd, {26'h0, v});
      chk(rstN, 0);
      apb(1'b1, IDX_RESET_CAUSE, 32'h3f);
      evt(4'b0010, 8'h37);
      evt(4'b0001, 8'h33);
      evt(4'b0100, 8'h3e);
      evt(4'b1000, 8'h3c);
      // Shortest period: 32 ticks, with a tick every cycle.
      cfg.guardModeConfig <= MODE_ALWAYS;
      apb(1'b1, IDX_GUARD_CONTROL_1, 32'h07);
      apb(1'b1, IDX_GUARD_CONTROL_0, 32'h0);
      r0 = rstN;
      n = 0;
      tickEn <= 1'b1;
      while (rstN == r0 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      tickEn <= 1'b0;
      chk({31'h0, n >= 31 && n <= 36}, 32'h1);
      apb(1'b0, IDX_RESET_CAUSE, 32'h0);
      chk({31'h0, rd[TO_BIT]}, 32'h0);
      // Half window: closed below count 16 of 32.
      apb(1'b1, IDX_GUARD_CONTROL_1, 32'h03);
      tickEn <= 1'b1;
      clr(1'b1);
      apb(1'b0, IDX_GUARD_CONTROL_0, 32'h0);
      clr(1'b1);
      apb(1'b0, IDX_GUARD_CONTROL_0, 32'h0);
      repeat (14 + $urandom % 6) @(posedge core_clk);
      clr(1'b0);
      repeat (16) @(posedge core_clk);
      clr(1'b1);
      tickEn <= 1'b0;
      apb(1'b0, IDX_RESET_CAUSE, 32'h0);
      chk({31'h0, rd[WV_BIT]}, 32'h0);
      // Each mode asleep: only always-on and enabled software mode wake.
      for (int m = 0; m < 4; m++) begin
         cfg.guardModeConfig <= 2'(m);
         apb(1'b1, IDX_GUARD_CONTROL_0, 32'h01);
         {r0, w0} = {rstN, wakeN};
         sleeping <= 1'b1;
         tickEn <= 1'b1;
         repeat (80) @(posedge core_clk);
         tickEn <= 1'b0;
         if (m == 3) chk({timeoutStatusN, powerdownStatusN}, 32'h0);
         sleeping <= 1'b0;
         chk({wakeN > w0, rstN > r0}, {m % 2 == 1, 1'b0});
      end
      close_out();
   end
endmodule
